// ==== clkstart_pkg.sv ====
// Shared constants, types and helper functions of the clock start-up controller.
package clkstart_pkg;

  // Clock rate and the internal oscillator warm-up time.
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned WARM_TIME_NS  = 2000;
  localparam int unsigned WARM_CYCLES   = (WARM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WARM_W        = 7;

  // Start-up timer length in external oscillator periods.
  localparam int unsigned OST_W     = 11;
  localparam logic [10:0] OST_COUNT = 11'h0400;

  // APB register byte offsets.
  localparam int unsigned ADDR_W      = 12;
  localparam logic [11:0] OFF_CONTROL = 12'h000;
  localparam logic [11:0] OFF_STATUS  = 12'h004;
  localparam logic [11:0] OFF_TRIM    = 12'h008;
  localparam logic [11:0] OFF_IRQ_ST  = 12'h00C;
  localparam logic [11:0] OFF_IRQ_EN  = 12'h010;
  localparam logic [11:0] OFF_IRQ_CLR = 12'h014;

  // Field layouts, masks and reset values.
  localparam int unsigned SCS_HI       = 1;
  localparam int unsigned SCS_LO       = 0;
  localparam logic [7:0]  CTRL_MASK    = 8'hFB;
  localparam logic [7:0]  RST_CONTROL  = 8'h00;
  localparam int unsigned TRIM_HI      = 5;
  localparam logic [5:0]  RST_TRIM     = 6'h00;
  localparam int unsigned STAT_STARTUP_TIMER_STATUS    = 5;
  localparam int unsigned STAT_INT_RDY = 0;
  localparam logic [1:0]  SCS_PRIMARY  = 2'h0;

  // Oscillator mode codes of the configuration word.
  localparam logic [2:0] MODE_LP = 3'h0;
  localparam logic [2:0] MODE_XT = 3'h1;
  localparam logic [2:0] MODE_HS = 3'h2;

  // Interrupt status bits.
  localparam int unsigned IRQ_W     = 3;
  localparam int unsigned IRQ_OST   = 0;
  localparam int unsigned IRQ_WARM  = 1;
  localparam int unsigned IRQ_ABORT = 2;

  // System clock source shown to the core.
  localparam logic [1:0] SRC_NONE = 2'h0;
  localparam logic [1:0] SRC_INT  = 2'h1;
  localparam logic [1:0] SRC_EXT  = 2'h2;

  // Configuration straps.
  typedef struct packed {
    logic       switchover_enable_cfg;
    logic       fail_safe_monitor_enable;
    logic [2:0] osc_mode_cfg;
    logic       power_up_timer_enable;
  } cfg_s;

  // APB request from the master.
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef enum logic [2:0] {
    ST_POR       = 3'b000,
    ST_WARM      = 3'b001,
    ST_TWO_SPEED = 3'b010,
    ST_OST_HOLD  = 3'b011,
    ST_INT       = 3'b100,
    ST_EXT       = 3'b101,
    ST_SLEEP     = 3'b110
  } clk_state_e;

  // True for the three crystal modes that need a stabilisation wait.
  function automatic logic is_crystal(input logic [2:0] mode);
    is_crystal = (mode == MODE_LP) || (mode == MODE_XT) || (mode == MODE_HS);
  endfunction

  // Two's-complement trim code to a monotonic step, minimum code gives zero.
  function automatic logic [5:0] trim_step(input logic [5:0] code);
    trim_step = {~code[5], code[4:0]};
  endfunction

endpackage

// ==== warm_timer.sv ====
// Internal oscillator warm-up delay timer.
module warm_timer (
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Control.
  input  wire logic start_i,
  output logic      done_o
);
  import clkstart_pkg::*;

  localparam logic [WARM_W-1:0] WARM_LOAD = WARM_W'(WARM_CYCLES);
  localparam logic [WARM_W-1:0] ONE       = 7'h01;

  logic [WARM_W-1:0] cnt_q, cnt_d;
  logic              busy_q, busy_d;
  logic              done_d;

  // A new start reloads the count, so a restart never ends early.
  always_comb begin
    cnt_d  = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    if (start_i) begin
      cnt_d  = WARM_LOAD;
      busy_d = 1'b1;
    end else if (busy_q) begin
      if (cnt_q == ONE) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q - ONE;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
      done_o <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
      done_o <= done_d;
    end
  end

  warm_end_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R4
    busy_q && cnt_q == ONE && !start_i |=> done_o && !busy_q)
    else $error("warm-up did not end at count one");
  warm_done_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R4
    done_o |-> $past(busy_q, 1) && !$past(start_i, 1))
    else $error("warm-up done without a running count");
endmodule

// ==== ost_counter.sv ====
// Oscillator start-up timer counting external oscillator periods.
module ost_counter (
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Control and oscillator ticks.
  input  wire logic start_i,
  input  wire logic abort_i,
  input  wire logic tick_i,
  output logic      busy_o,
  output logic      done_o
);
  import clkstart_pkg::*;

  localparam logic [OST_W-1:0] ONE  = 11'h001;
  localparam logic [OST_W-1:0] LAST = OST_COUNT - ONE;

  logic [OST_W-1:0] cnt_q, cnt_d;
  logic             busy_d, done_d;

  // Abort wins over a start and over the final tick.
  always_comb begin
    cnt_d  = cnt_q;
    busy_d = busy_o;
    done_d = 1'b0;
    if (abort_i) begin
      busy_d = 1'b0;
      cnt_d  = '0;
    end else if (start_i) begin
      busy_d = 1'b1;
      cnt_d  = '0;
    end else if (busy_o && tick_i) begin
      if (cnt_q == LAST) begin // R5
        busy_d = 1'b0;
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q + ONE;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_q  <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      busy_o <= busy_d;
      done_o <= done_d;
    end
  end

  ost_count_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R5
    done_o |-> $past(tick_i, 1) && $past(cnt_q, 1) == LAST)
    else $error("start-up timer ended before full count");
  ost_abort_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R11
    abort_i |=> !busy_o && !done_o)
    else $error("start-up timer survived an abort");
endmodule

// ==== clk_startup_ctrl.sv ====
// Clock source selection and two-speed start-up controller with APB registers.
// Notes on behaviour
// R1: Two-speed start-up is on only with switchover or the fail-safe monitor set, select field 00 and a crystal mode.
// R2: Start-up is entered after power-on reset, after the power-up timer if enabled, and on every wake-up.
// R3: An enabled fail-safe monitor turns two-speed start-up on regardless of the switchover bit.
// R4: Entering the internal oscillator from sleep or reset waits the warm-up delay before use.
// R5: A crystal oscillator is not used until the start-up timer has counted 1024 of its periods.
// R6: The six-bit trim moves the internal oscillator, 000000 calibrated, 011111 highest, 100000 lowest.
// R7: Unimplemented register bits, including the top two trim bits, read as zero.
// R8: The trim code is a two's-complement offset stepping frequency monotonically.
// R9: During two-speed start-up the core runs from the internal oscillator while the crystal settles.
// R10: When the start-up count completes the status flag is set and execution moves to the crystal.
// R11: Sleep during start-up aborts the wait and leaves the status flag clear.
// R12: With a non-crystal mode two-speed start-up is off since no wait is needed.
//
// The address map and register access over APB are this design's own decisions.
module clk_startup_ctrl (
  // Clock and reset.
  input  wire logic                   CLK_I,
  input  wire logic                   NRST_I,
  // Configuration straps and power events.
  input  wire clkstart_pkg::cfg_s     CFG_I,
  input  wire logic                   POWER_UP_TIMER_DONE_I,
  input  wire logic                   SLEEP_I,
  input  wire logic                   WAKE_I,
  input  wire logic                   EXT_OSC_TICK_I,
  // APB slave.
  input  wire clkstart_pkg::apb_req_s APB_REQ_I,
  output logic                        PREADY_O,
  output logic [31:0]                 PRDATA_O,
  output logic                        PSLVERR_O,
  // Clock source and trim outputs.
  output logic [1:0]                  SYS_CLK_SEL_O,
  output logic                        TWO_SPEED_O,
  output logic [5:0]                  TRIM_STEP_O,
  output logic                        IRQ_O
);
  import clkstart_pkg::*;

  clk_state_e        state_q, state_d;
  logic [1:0]        src_d;
  logic              two_q, two_d;
  logic              startup_timer_status_q, startup_timer_status_d;
  logic [7:0]        ctrl_q, ctrl_d;
  logic [5:0]        trim_q, trim_d;
  logic [5:0]        step_d;
  logic [IRQ_W-1:0]  irq_st_q, irq_st_d;
  logic [IRQ_W-1:0]  irq_en_q, irq_en_d;
  logic [IRQ_W-1:0]  irq_set;
  logic              irq_d;
  logic              pready_d, pslverr_d;
  logic [31:0]       prdata_d;
  logic              warm_start, warm_done;
  logic              ost_start, ost_abort, ost_busy, ost_done;
  logic              two_speed_en, waiting_ost, por_ready, sleep_go;
  logic              access, wr_done, rd_capture, mapped;
  logic [1:0]        system_clock_select;
  logic [7:0]        status_val;
  logic [31:0]       rd_val;

  assign system_clock_select = ctrl_q[SCS_HI:SCS_LO];

  // The fail-safe monitor forces the switchover on; a non-crystal mode always turns it off.
  assign two_speed_en = (CFG_I.switchover_enable_cfg || CFG_I.fail_safe_monitor_enable) // R1 R3
                        && (system_clock_select == SCS_PRIMARY) && is_crystal(CFG_I.osc_mode_cfg); // R12

  // The power-up timer gates the first start-up only when it is enabled.
  assign por_ready   = !CFG_I.power_up_timer_enable || POWER_UP_TIMER_DONE_I; // R2
  assign waiting_ost = ost_busy;
  assign sleep_go    = SLEEP_I && (state_q != ST_POR) && (state_q != ST_SLEEP);

  // Start-up state machine; the warm-up and start-up timers are kicked from here.
  always_comb begin
    state_d    = state_q;
    two_d      = two_q;
    startup_timer_status_d     = startup_timer_status_q;
    warm_start = 1'b0;
    ost_start  = 1'b0;
    ost_abort  = 1'b0;
    if (sleep_go) begin
      state_d   = ST_SLEEP; // R11
      ost_abort = 1'b1;
      startup_timer_status_d    = 1'b0;
      two_d     = 1'b0;
    end else begin
      case (state_q)
        ST_POR, ST_SLEEP: begin
          if ((state_q == ST_POR) ? por_ready : WAKE_I) begin // R2
            startup_timer_status_d = 1'b0;
            if (two_speed_en) begin
              state_d    = ST_WARM; // R9
              two_d      = 1'b1;
              warm_start = 1'b1;
              ost_start  = 1'b1;
            end else if (system_clock_select == SCS_PRIMARY && is_crystal(CFG_I.osc_mode_cfg)) begin
              state_d   = ST_OST_HOLD; // R5
              ost_start = 1'b1;
            end else if (system_clock_select == SCS_PRIMARY) begin
              state_d = ST_EXT; // R12
            end else begin
              state_d    = ST_WARM; // R4
              warm_start = 1'b1;
            end
          end
        end
        ST_WARM: begin
          if (two_q && ost_done) begin
            state_d = ST_EXT; // R10
            startup_timer_status_d  = 1'b1;
            two_d   = 1'b0;
          end else if (warm_done) begin
            state_d = two_q ? ST_TWO_SPEED : ST_INT; // R4
          end
        end
        ST_TWO_SPEED, ST_OST_HOLD: begin
          if (ost_done) begin
            state_d = ST_EXT; // R10
            startup_timer_status_d  = 1'b1;
            two_d   = 1'b0;
          end
        end
        ST_INT: begin
          if (system_clock_select == SCS_PRIMARY && is_crystal(CFG_I.osc_mode_cfg)) begin
            state_d   = ST_OST_HOLD; // R5
            ost_start = 1'b1;
          end else if (system_clock_select == SCS_PRIMARY) begin
            state_d = ST_EXT;
          end
        end
        ST_EXT: begin
          if (system_clock_select != SCS_PRIMARY) begin
            state_d    = ST_WARM;
            warm_start = 1'b1;
          end
        end
        default: begin
          state_d = ST_POR;
        end
      endcase
    end
  end

  // The core sees a source only once it is usable; held states show none.
  always_comb begin
    case (state_d)
      ST_TWO_SPEED, ST_INT: src_d = SRC_INT; // R9
      ST_EXT:               src_d = SRC_EXT;
      default:              src_d = SRC_NONE;
    endcase
  end

  warm_timer u_warm (
    .clk_i   (CLK_I),
    .rst_n_i (NRST_I),
    .start_i (warm_start),
    .done_o  (warm_done)
  );

  ost_counter u_ost (
    .clk_i   (CLK_I),
    .rst_n_i (NRST_I),
    .start_i (ost_start),
    .abort_i (ost_abort),
    .tick_i  (EXT_OSC_TICK_I),
    .busy_o  (ost_busy),
    .done_o  (ost_done)
  );

  // APB decode; pready rises one access cycle late so every output stays a flop.
  assign access     = APB_REQ_I.psel && APB_REQ_I.penable;
  assign rd_capture = access && !PREADY_O;
  assign wr_done    = access && PREADY_O && APB_REQ_I.pwrite;

  always_comb begin
    status_val               = 8'h00; // R7
    status_val[STAT_STARTUP_TIMER_STATUS]    = startup_timer_status_q;
    status_val[STAT_INT_RDY] = (state_q == ST_TWO_SPEED) || (state_q == ST_INT);
    mapped                   = 1'b1;
    rd_val                   = 32'h0000_0000;
    if (APB_REQ_I.paddr == OFF_CONTROL) begin
      rd_val[7:0] = ctrl_q;
    end else if (APB_REQ_I.paddr == OFF_STATUS) begin
      rd_val[7:0] = status_val;
    end else if (APB_REQ_I.paddr == OFF_TRIM) begin
      rd_val[TRIM_HI:0] = trim_q; // R7
    end else if (APB_REQ_I.paddr == OFF_IRQ_ST) begin
      rd_val[IRQ_W-1:0] = irq_st_q;
    end else if (APB_REQ_I.paddr == OFF_IRQ_EN) begin
      rd_val[IRQ_W-1:0] = irq_en_q;
    end else if (APB_REQ_I.paddr == OFF_IRQ_CLR) begin
      rd_val = 32'h0000_0000;
    end else begin
      mapped = 1'b0;
    end
  end

  // Register writes land on the completing edge; a write to an unmapped word is dropped.
  always_comb begin
    pready_d  = rd_capture;
    prdata_d  = rd_capture ? rd_val : PRDATA_O;
    pslverr_d = rd_capture && !mapped;
    ctrl_d    = ctrl_q;
    trim_d    = trim_q;
    irq_en_d  = irq_en_q;
    if (wr_done && APB_REQ_I.paddr == OFF_CONTROL) begin
      ctrl_d = APB_REQ_I.pwdata[7:0] & CTRL_MASK; // R7
    end else if (wr_done && APB_REQ_I.paddr == OFF_TRIM) begin
      trim_d = APB_REQ_I.pwdata[TRIM_HI:0]; // R6
    end else if (wr_done && APB_REQ_I.paddr == OFF_IRQ_EN) begin
      irq_en_d = APB_REQ_I.pwdata[IRQ_W-1:0];
    end
    step_d = trim_step(trim_q); // R8
  end

  // Sticky events; a new event beats a clear written in the same cycle.
  always_comb begin
    irq_set            = '0;
    irq_set[IRQ_OST]   = ost_done && !sleep_go;
    irq_set[IRQ_WARM]  = warm_done;
    irq_set[IRQ_ABORT] = sleep_go && waiting_ost;
    irq_st_d           = irq_st_q;
    if (wr_done && APB_REQ_I.paddr == OFF_IRQ_CLR) begin
      irq_st_d = irq_st_q & ~APB_REQ_I.pwdata[IRQ_W-1:0];
    end
    irq_st_d = irq_st_d | irq_set;
    irq_d    = |(irq_st_d & irq_en_d);
  end

  // All state and every top-level output register.
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      state_q       <= ST_POR;
      two_q         <= 1'b0;
      startup_timer_status_q        <= 1'b0;
      ctrl_q        <= RST_CONTROL;
      trim_q        <= RST_TRIM;
      irq_st_q      <= '0;
      irq_en_q      <= '0;
      PREADY_O      <= 1'b0;
      PRDATA_O      <= 32'h0000_0000;
      PSLVERR_O     <= 1'b0;
      SYS_CLK_SEL_O <= SRC_NONE;
      TWO_SPEED_O   <= 1'b0;
      TRIM_STEP_O   <= trim_step(RST_TRIM); // Calibrated mid step, so the oscillator starts untrimmed.
      IRQ_O         <= 1'b0;
    end else begin
      state_q       <= state_d;
      two_q         <= two_d;
      startup_timer_status_q        <= startup_timer_status_d;
      ctrl_q        <= ctrl_d;
      trim_q        <= trim_d;
      irq_st_q      <= irq_st_d;
      irq_en_q      <= irq_en_d;
      PREADY_O      <= pready_d;
      PRDATA_O      <= prdata_d;
      PSLVERR_O     <= pslverr_d;
      SYS_CLK_SEL_O <= src_d;
      TWO_SPEED_O   <= two_d;
      TRIM_STEP_O   <= step_d;
      IRQ_O         <= irq_d;
    end
  end

  two_speed_gate_a: assert property (@(posedge CLK_I) disable iff (!NRST_I) // R1
    $rose(two_q) |-> $past(two_speed_en, 1))
    else $error("two-speed start-up entered without its enables");
  ext_switch_a: assert property (@(posedge CLK_I) disable iff (!NRST_I) // R10
    ost_done && !sleep_go && (state_q inside {ST_TWO_SPEED, ST_OST_HOLD})
    |=> startup_timer_status_q && state_q == ST_EXT && SYS_CLK_SEL_O == SRC_EXT)
    else $error("completed start-up count did not move to crystal");
  sleep_abort_a: assert property (@(posedge CLK_I) disable iff (!NRST_I) // R11
    sleep_go |=> state_q == ST_SLEEP && !startup_timer_status_q ##1 !startup_timer_status_q)
    else $error("sleep did not abort start-up");
  warm_use_a: assert property (@(posedge CLK_I) disable iff (!NRST_I) // R4
    $past(state_q, 1) == ST_WARM && SYS_CLK_SEL_O == SRC_INT |-> $past(warm_done, 1))
    else $error("internal clock used before warm-up");
  ost_hold_a: assert property (@(posedge CLK_I) disable iff (!NRST_I) // R5
    state_q == ST_OST_HOLD |-> SYS_CLK_SEL_O == SRC_NONE && (ost_busy || ost_done))
    else $error("crystal used before start-up count");
  two_speed_run_a: assert property (@(posedge CLK_I) disable iff (!NRST_I) // R9
    state_q == ST_TWO_SPEED |-> SYS_CLK_SEL_O == SRC_INT && TWO_SPEED_O)
    else $error("two-speed start-up not on internal clock");
  trim_read_a: assert property (@(posedge CLK_I) disable iff (!NRST_I) // R7
    rd_capture && APB_REQ_I.paddr == OFF_TRIM
    |=> PREADY_O && PRDATA_O == {26'h000_0000, $past(trim_q, 1)})
    else $error("trim read shows unimplemented bits");
  trim_mid_a: assert property (@(posedge CLK_I) disable iff (!NRST_I) // R6 R8
    trim_q == 6'h00 ##1 trim_q == 6'h00 |-> TRIM_STEP_O == 6'h20)
    else $error("calibrated trim code not at mid step");
  wake_entry_a: assert property (@(posedge CLK_I) disable iff (!NRST_I) // R2
    state_q == ST_SLEEP && WAKE_I && !SLEEP_I |=> state_q != ST_SLEEP)
    else $error("wake-up did not enter start-up");
endmodule

// ==== ext_osc_model.sv ====
// Behavioural external crystal that gives one tick pulse per oscillator period.
module ext_osc_model (
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Run control and period in system clock cycles.
  input  wire logic       run_i,
  input  wire logic [3:0] period_i,
  // Oscillator tick.
  output logic            tick_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [3:0] cnt_q;

  // The crystal stands still until it is powered, so no stale tick leaks into a start-up count.
  always @(posedge clk_i) begin
    if (!rst_n_i || !run_i) begin
      cnt_q  <= 4'h0;
      tick_o <= 1'b0;
    end else begin
      cnt_q  <= (cnt_q == period_i - 4'h1) ? 4'h0 : cnt_q + 4'h1;
      tick_o <= (cnt_q == period_i - 4'h1);
    end
  end
endmodule

// ==== testbench.sv ====
// Self-checking testbench of the clock start-up controller.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import clkstart_pkg::*;

  typedef struct packed {
    logic        wr;
    logic [11:0] addr;
    logic [31:0] wd;
    logic [31:0] exp;
    logic        err;
  } row_s;

  logic        clk, nrst, power_up_timer_done, sleep, wake, tick, osc_run;
  logic        pready, pslverr, two_speed, irq;
  logic [31:0] prdata;
  logic [1:0]  sel;
  logic [5:0]  step;
  logic [3:0]  period;
  cfg_s        cfg;
  apb_req_s    req;
  int          errors, num_checks, tcnt;

  // Register table cases: one row per bus transfer, run in order.
  row_s rows [10] = '{
    '{1'b0, OFF_CONTROL, 32'h0, 32'h0, 1'b0},
    '{1'b0, OFF_TRIM, 32'h0, 32'h0, 1'b0},
    '{1'b1, OFF_TRIM, 32'hFFFF_FFFF, 32'h0, 1'b0},
    '{1'b0, OFF_TRIM, 32'h0, 32'h3F, 1'b0},
    '{1'b1, OFF_CONTROL, 32'hFFFF_FFFF, 32'h0, 1'b0},
    '{1'b0, OFF_CONTROL, 32'h0, 32'hFB, 1'b0},
    '{1'b1, OFF_CONTROL, 32'h0, 32'h0, 1'b0},
    '{1'b0, OFF_IRQ_CLR, 32'h0, 32'h0, 1'b0},
    '{1'b0, 12'h018, 32'h0, 32'h0, 1'b1},
    '{1'b1, 12'h018, 32'h0, 32'h0, 1'b1}
  };

  clk_startup_ctrl DUT (
    .CLK_I(clk), .NRST_I(nrst), .CFG_I(cfg), .POWER_UP_TIMER_DONE_I(power_up_timer_done), .SLEEP_I(sleep),
    .WAKE_I(wake), .EXT_OSC_TICK_I(tick), .APB_REQ_I(req), .PREADY_O(pready),
    .PRDATA_O(prdata), .PSLVERR_O(pslverr), .SYS_CLK_SEL_O(sel), .TWO_SPEED_O(two_speed),
    .TRIM_STEP_O(step), .IRQ_O(irq)
  );

  ext_osc_model osc (.clk_i(clk), .rst_n_i(nrst), .run_i(osc_run), .period_i(period), .tick_o(tick));

  // 25 MHz system clock.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Ticks seen by the controller since the crystal was powered.
  always @(posedge clk) begin
    if (!osc_run) tcnt <= 0;
    else if (tick) tcnt <= tcnt + 1;
  end

  task automatic results();
    $display("Checks %0d, errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic timeout(input string name);
    errors++;
    $display("MISMATCH %s expected completion seen timeout", name);
    results();
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk);
    req <= '{1'b1, 1'b0, wr, a, wd};
    @(posedge clk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) timeout("pready");
    rd = prdata;
    err = pslverr;
    req <= '0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] d;
    logic e;
    apb(1'b1, a, wd, d, e);
  endtask

  task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] d;
    logic e;
    apb(1'b0, a, 32'h0, d, e);
    chk(name, exp, d & m);
  endtask

  // Counts edges until the clock select (or the two-speed flag) shows the wanted value.
  task automatic wait_out(input bit ts, input logic [1:0] exp, input int bound, output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while ((ts ? {1'b0, two_speed} : sel) !== exp && n < bound);
    if ((ts ? {1'b0, two_speed} : sel) !== exp) timeout("clock wait");
  endtask

  // Straps only change under reset, since the controller treats them as static.
  task automatic do_reset(input cfg_s c, input logic [3:0] p);
    @(posedge clk);
    nrst <= 1'b0;
    cfg <= c;
    power_up_timer_done <= 1'b0;
    osc_run <= 1'b0;
    period <= p;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
  endtask

  // The power-up timer expiry marks the entry edge, one edge after this call.
  task automatic start();
    @(posedge clk);
    power_up_timer_done <= 1'b1;
    osc_run <= 1'b1;
  endtask

  task automatic pulse_sleep(input bit w);
    @(posedge clk);
    if (w) wake <= 1'b1;
    else sleep <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    sleep <= 1'b0;
  endtask

  initial begin
    int n;
    logic [31:0] d;
    logic e;
    nrst = 1'b0;
    cfg = '0;
    power_up_timer_done = 1'b0;
    sleep = 1'b0;
    wake = 1'b0;
    osc_run = 1'b0;
    period = 4'h4;
    req = '0;
    errors = 0;
    num_checks = 0;
    do_reset('{1'b1, 1'b0, MODE_XT, 1'b1}, 4'h4);
    #1;
    chk("sel_reset", 32'h0, {30'h0, sel});
    chk("step_reset", 32'h20, {26'h0, step});
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].addr, rows[i].wd, d, e);
      if (!rows[i].wr) chk("reg_data", rows[i].exp, d);
      chk("reg_err", {31'h0, rows[i].err}, {31'h0, e});
    end
    // Codes walked from the lowest to the highest frequency must step by one each time.
    for (int i = 0; i < 64; i++) begin
      wr(OFF_TRIM, {26'h0, 6'(i) ^ 6'h20});
      repeat (2) @(posedge clk);
      chk("trim_step", 32'(i), {26'h0, step});
    end
    wr(OFF_TRIM, 32'h0);
    wr(OFF_IRQ_EN, 32'h0000_0002);
    // Crystal start-up with two-speed mode on.
    start();
    wait_out(1'b1, 2'h1, 5, n);
    chk("two_speed_entry", 32'd1, 32'(n));
    chk("sel_warm", 32'h0, {30'h0, sel});
    wait_out(1'b0, 2'h1, 100, n);
    chk("warm_edges", 32'd51, 32'(n));
    chk("two_speed_run", 32'h1, {31'h0, two_speed});
    #40;
    chk("irq_warm", 32'h1, {31'h0, irq});
    wr(OFF_IRQ_EN, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq_masked", 32'h0, {31'h0, irq});
    wait_out(1'b0, 2'h2, 5000, n);
    chk("ost_ticks", 32'd1024, 32'(tcnt));
    chk("two_speed_end", 32'h0, {31'h0, two_speed});
    wr(OFF_STATUS, 32'h0);
    rd_chk("startup_timer_status_set", OFF_STATUS, 32'h20, 32'h20);
    rd_chk("irq_status", OFF_IRQ_ST, 32'hFFFF_FFFF, 32'h3);
    wr(OFF_IRQ_EN, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq_ost", 32'h1, {31'h0, irq});
    wr(OFF_IRQ_CLR, 32'h3);
    repeat (2) @(posedge clk);
    chk("irq_cleared", 32'h0, {31'h0, irq});
    rd_chk("irq_status_clr", OFF_IRQ_ST, 32'hFFFF_FFFF, 32'h0);
    // Leaving the crystal for the internal clock, then back through a full count.
    wr(OFF_CONTROL, 32'h1);
    wait_out(1'b0, 2'h1, 100, n);
    chk("ext_to_int_edges", 32'd52, 32'(n));
    wr(OFF_CONTROL, 32'h0);
    repeat (2) @(posedge clk);
    chk("int_to_ext_held", 32'h0, {30'h0, sel});
    wait_out(1'b0, 2'h2, 5000, n);
    // Sleep while the crystal count runs, then wake.
    do_reset('{1'b1, 1'b0, MODE_XT, 1'b1}, 4'h2);
    start();
    wait_out(1'b0, 2'h1, 100, n);
    pulse_sleep(1'b0);
    wait_out(1'b0, 2'h0, 3, n);
    repeat (2200) @(posedge clk);
    chk("sel_asleep", 32'h0, {30'h0, sel});
    rd_chk("startup_timer_status_clear", OFF_STATUS, 32'h20, 32'h0);
    rd_chk("irq_abort", OFF_IRQ_ST, 32'h4, 32'h4);
    pulse_sleep(1'b1);
    wait_out(1'b1, 2'h1, 5, n);
    // External clock mode needs no wait.
    do_reset('{1'b1, 1'b0, 3'h4, 1'b1}, 4'h2);
    start();
    wait_out(1'b0, 2'h2, 5, n);
    chk("ext_edges", 32'd1, 32'(n));
    chk("ext_two_speed", 32'h0, {31'h0, two_speed});
    // Switchover off: the core waits for the full crystal count.
    do_reset('{1'b0, 1'b0, MODE_HS, 1'b1}, 4'h2);
    start();
    repeat (100) @(posedge clk);
    chk("no_switchover", 32'h0, {31'h0, two_speed});
    chk("sel_held", 32'h0, {30'h0, sel});
    wait_out(1'b0, 2'h2, 5000, n);
    // An enabled fail-safe monitor forces two-speed mode.
    do_reset('{1'b0, 1'b1, MODE_LP, 1'b1}, 4'h2);
    start();
    wait_out(1'b1, 2'h1, 5, n);
    // A non-zero select field keeps two-speed mode off.
    do_reset('{1'b1, 1'b0, MODE_XT, 1'b1}, 4'h2);
    wr(OFF_CONTROL, 32'h1);
    start();
    wait_out(1'b0, 2'h1, 100, n);
    chk("scs_warm_edges", 32'd52, 32'(n));
    chk("scs_two_speed", 32'h0, {31'h0, two_speed});
    results();
  end
endmodule
